// File: hw/pdpm_map.vh
`ifndef PDPM_MAP_VH
`define PDPM_MAP_VH
// clock period in ns (20 MHz)
`define PDPM_CLK_NS        50
// shutdown low time, ns (1.5 ms)
`define PDPM_OFF_NS        1500000
`define PDPM_OFF_CYC       ((`PDPM_OFF_NS + `PDPM_CLK_NS - 1) / `PDPM_CLK_NS)
// current settling time, ns (10 us)
`define PDPM_SETTLE_NS     10000
`define PDPM_SETTLE_CYC    (`PDPM_SETTLE_NS / `PDPM_CLK_NS)
// mode filter delays, ns (120 us and 400 us)
`define PDPM_DLY1_NS       120000
`define PDPM_DLY1_CYC      (`PDPM_DLY1_NS / `PDPM_CLK_NS)
`define PDPM_DLY2_NS       400000
`define PDPM_DLY2_CYC      (`PDPM_DLY2_NS / `PDPM_CLK_NS)
// third step delay, not given: reuse the first filter delay
`define PDPM_DLY3_CYC      (`PDPM_DLY1_NS / `PDPM_CLK_NS)
// pump ratio codes on the mode output
`define PDPM_RATIO_1X      2'h0
`define PDPM_RATIO_133     2'h1
`define PDPM_RATIO_15      2'h2
`define PDPM_RATIO_2X      2'h3
`define PDPM_STEP_ZERO     4'h0
`define PDPM_STEP_FULL     4'hF
`define PDPM_STEP_ONE      4'h1
`define PDPM_CNT_W         16
// span counter start and step, sized to the counter width
`define PDPM_CNT_ZERO      16'h0000
`define PDPM_CNT_ONE       16'h0001
// all six sinks released, zero current
`define PDPM_SINKS_OFF     6'h00
`endif

// File: hw/pdpm_ctrl.v
`timescale 1ns/10ps
`include "pdpm_map.vh"
module pdpm_ctrl #(
  parameter OFF_CYC = `PDPM_OFF_CYC,
  parameter DLY1    = `PDPM_DLY1_CYC,
  parameter DLY2    = `PDPM_DLY2_CYC,
  parameter DLY3    = `PDPM_DLY3_CYC
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       program_line,
  input  wire       under_voltage,
  input  wire       headroom_low,
  input  wire       headroom_1x_ok,
  output reg        enabled,
  output reg  [3:0] current_step,
  output reg  [5:0] sink_oe,
  output reg  [1:0] pump_ratio,
  output reg        settling
);

  // states of the pump sequencer, one-hot
  localparam [3:0] ST_1X  = 4'h1;
  localparam [3:0] ST_133 = 4'h2;
  localparam [3:0] ST_15  = 4'h4;
  localparam [3:0] ST_2X  = 4'h8;

  // settle span kept as an integer so its low bits are picked on purpose
  localparam integer SETTLE = `PDPM_SETTLE_CYC;

  reg                    line_q;
  reg [`PDPM_CNT_W-1:0]  low_cnt;
  reg [3:0]              step;
  reg [`PDPM_CNT_W-1:0]  settle_cnt;
  reg [3:0]              state;
  reg [3:0]              next_state;
  reg [`PDPM_CNT_W-1:0]  dly_cnt;
  reg [`PDPM_CNT_W-1:0]  next_dly;
  wire                   rise;
  wire                   off_now;
  wire                   settle_end;

  // wraps 15 back to zero
  function [3:0] step_inc;
    input [3:0] s;
    begin
      step_inc = (s == `PDPM_STEP_FULL) ? `PDPM_STEP_ZERO : s + `PDPM_STEP_ONE;
    end
  endfunction

  // true on the last cycle of a span of limit cycles
  function cnt_last;
    input [`PDPM_CNT_W-1:0] cnt;
    input [`PDPM_CNT_W-1:0] limit;
    begin
      cnt_last = (cnt == limit - `PDPM_CNT_ONE);
    end
  endfunction

  // one more cycle on a span counter
  function [`PDPM_CNT_W-1:0] cnt_inc;
    input [`PDPM_CNT_W-1:0] cnt;
    begin
      cnt_inc = cnt + `PDPM_CNT_ONE;
    end
  endfunction

  // ratio code shown on the mode output for a sequencer state
  function [1:0] ratio_of;
    input [3:0] st;
    begin
      case (st)
        ST_133:  ratio_of = `PDPM_RATIO_133;
        ST_15:   ratio_of = `PDPM_RATIO_15;
        ST_2X:   ratio_of = `PDPM_RATIO_2X;
        default: ratio_of = `PDPM_RATIO_1X;
      endcase
    end
  endfunction

  // line_q resets low, the idle level, so no false edge follows reset
  assign rise       = program_line & ~line_q;
  // the timeout compares the count already reached, so the line low for OFF_CYC cycles shuts down
  assign off_now    = cnt_last(low_cnt, OFF_CYC[`PDPM_CNT_W-1:0]) & ~program_line;
  // last cycle of the settle window
  assign settle_end = cnt_last(settle_cnt, SETTLE[`PDPM_CNT_W-1:0]);

  // enable, low-time detector and step counter
  // the rise that wakes the device is swallowed: it only enables
  always @(posedge clk) begin
    if (rst || under_voltage) begin
      line_q       <= 1'b0;
      low_cnt      <= `PDPM_CNT_ZERO;
      enabled      <= 1'b0;
      step         <= `PDPM_STEP_ZERO;
    end else begin
      line_q <= program_line;
      // any high level restarts the low-time measurement
      if (program_line)
        low_cnt <= `PDPM_CNT_ZERO;
      else if (enabled && !off_now)
        low_cnt <= cnt_inc(low_cnt);
      if (enabled && off_now) begin
        enabled <= 1'b0;
        step    <= `PDPM_STEP_ZERO;
        low_cnt <= `PDPM_CNT_ZERO;
      end else if (!enabled && program_line) begin
        enabled <= 1'b1;
      end else if (enabled && rise) begin
        step <= step_inc(step);
      end
    end
  end

  // settle window: new step reaches the sinks after the settling time
  // steps taken during a window are merged; the latest one wins at its end
  always @(posedge clk) begin
    if (rst || under_voltage) begin
      settle_cnt   <= `PDPM_CNT_ZERO;
      settling     <= 1'b0;
      current_step <= `PDPM_STEP_ZERO;
      sink_oe      <= `PDPM_SINKS_OFF;
    end else begin
      sink_oe <= {6{enabled}};
      if (!enabled) begin
        current_step <= `PDPM_STEP_ZERO;
        settle_cnt   <= `PDPM_CNT_ZERO;
        settling     <= 1'b0;
      end else if (step != current_step && !settling) begin
        settling   <= 1'b1;
        settle_cnt <= `PDPM_CNT_ZERO;
      end else if (settling) begin
        if (settle_end) begin
          current_step <= step;
          settling     <= 1'b0;
        end else
          settle_cnt <= cnt_inc(settle_cnt);
      end
    end
  end

  // pump sequencer next state; the filter delay restarts when headroom recovers
  // a return to 1x wins over a further step up, so a boosted mode never lingers
  always @* begin
    next_state = state;
    next_dly   = `PDPM_CNT_ZERO;
    case (state)
      ST_1X: begin
        if (headroom_low) begin
          if (cnt_last(dly_cnt, DLY1[`PDPM_CNT_W-1:0]))
            next_state = ST_133;
          else
            next_dly = cnt_inc(dly_cnt);
        end
      end
      ST_133: begin
        if (headroom_1x_ok)
          next_state = ST_1X;
        else if (headroom_low) begin
          if (cnt_last(dly_cnt, DLY2[`PDPM_CNT_W-1:0]))
            next_state = ST_15;
          else
            next_dly = cnt_inc(dly_cnt);
        end
      end
      ST_15: begin
        if (headroom_1x_ok)
          next_state = ST_1X;
        else if (headroom_low) begin
          if (cnt_last(dly_cnt, DLY3[`PDPM_CNT_W-1:0]))
            next_state = ST_2X;
          else
            next_dly = cnt_inc(dly_cnt);
        end
      end
      // top ratio: only the way back to 1x is left
      ST_2X: begin
        if (headroom_1x_ok)
          next_state = ST_1X;
      end
      default: next_state = ST_1X;
    endcase
  end

  // sequencer registers; pump held in 1x while shut down
  // the ratio output is registered from next_state so it moves with the state
  always @(posedge clk) begin
    if (rst || under_voltage || !enabled) begin
      state      <= ST_1X;
      dly_cnt    <= `PDPM_CNT_ZERO;
      pump_ratio <= `PDPM_RATIO_1X;
    end else begin
      state      <= next_state;
      dly_cnt    <= next_dly;
      pump_ratio <= ratio_of(next_state);
    end
  end

endmodule // pdpm_ctrl

// File: tb/pdpm_checker.sv
`timescale 1ns/10ps
module pdpm_checker #(parameter OFF_CYC = 40) (
  input wire       clk,
  input wire       rst,
  input wire       program_line,
  input wire       under_voltage,
  input wire       headroom_low,
  input wire       headroom_1x_ok,
  input wire       enabled,
  input wire [3:0] current_step,
  input wire [5:0] sink_oe,
  input wire [1:0] pump_ratio,
  input wire       settling
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  int low_cnt;
  // low cycles seen while enabled, margin of two for sampling
  always @(posedge clk) low_cnt <= (enabled && !program_line) ? low_cnt + 1 : 0;
  a_off_timeout: assert property (low_cnt > OFF_CYC + 1 |-> !enabled) else $error("no shutdown");
  a_short_low: assert property (enabled && !under_voltage && low_cnt < OFF_CYC - 2 |=> enabled)
    else $error("early shutdown");
  a_off_clear: assert property ($fell(enabled) && !under_voltage |=> sink_oe == 6'h00 && current_step == 4'h0)
    else $error("sinks not cleared");
  a_enable_zero: assert property ($rose(enabled) |-> current_step == 4'h0) else $error("nonzero on enable");
  a_ratio_order: assert property ($changed(pump_ratio) |-> pump_ratio == 2'h0 || pump_ratio == $past(pump_ratio) + 2'h1)
    else $error("bad ratio step");
  a_ratio_delay: assert property ($rose(pump_ratio == 2'h1) |-> $past(headroom_low, 8)) else $error("ratio too early");
  a_ratio_return: assert property (pump_ratio != 2'h0 && headroom_1x_ok |=> pump_ratio == 2'h0)
    else $error("no return to 1x");
  a_settle_time: assert property ($rose(settling) |-> ##[190:205] $changed(current_step)) else $error("settle time");
  a_uv_clear: assert property (under_voltage |=> !enabled && current_step == 4'h0) else $error("uv not cleared");
  c_wrap: cover property ($changed(current_step) && current_step == 4'h0 && enabled);
  c_top: cover property (pump_ratio == 2'h3);
  c_off: cover property ($fell(enabled));
endmodule // pdpm_checker
bind pdpm_ctrl pdpm_checker #(.OFF_CYC(OFF_CYC)) chk_i (.clk(clk), .rst(rst), .program_line(program_line),
  .under_voltage(under_voltage), .headroom_low(headroom_low), .headroom_1x_ok(headroom_1x_ok), .enabled(enabled),
  .current_step(current_step), .sink_oe(sink_oe), .pump_ratio(pump_ratio), .settling(settling));

// File: tb/pdpm_host.sv
`timescale 1ns/10ps
module pdpm_host (
  input  wire clk,
  output reg  program_line
);
  initial program_line = 1'b0;
  // step_pulse keeps both phases at 4 cycles or more, the direct calls hold high only 3 cycles; low stays under 2000
  task automatic pulse(input int lo, input int hi);
    @(posedge clk) #1 program_line = 1'b0;
    repeat (lo) @(posedge clk);
    #1 program_line = 1'b1;
    repeat (hi) @(posedge clk);
  endtask
endmodule // pdpm_host

// File: tb/test_pulse_dimming_and_pump_mode_control.sv
`timescale 1ns/10ps
module test_pulse_dimming_and_pump_mode_control;
  localparam OFF = 40;
  logic       clk, rst, uv, hl, ok;
  wire        en, pl, st;
  wire  [3:0] step;
  wire  [5:0] oe;
  wire  [1:0] pr;
  int         num_errors, checked;
  logic [3:0] exp_q[$];
  logic [3:0] prev;
  logic [7:0] lf = 8'h24;
  pdpm_ctrl #(.OFF_CYC(OFF), .DLY1(10), .DLY2(20), .DLY3(10)) DUT (.clk(clk), .rst(rst), .program_line(pl),
    .under_voltage(uv), .headroom_low(hl), .headroom_1x_ok(ok), .enabled(en), .current_step(step),
    .sink_oe(oe), .pump_ratio(pr), .settling(st));
  pdpm_host host (.clk(clk), .program_line(pl));
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // note the step, pulse with random phases, then let it settle
  task step_pulse(input logic [3:0] e, input int lo);
    lf = lfsr_next(lf);
    exp_q.push_back(e);
    host.pulse(lo + lf[2:0], 4 + lf[5:3]);
    chk(st, 8'h01, "settling");
    repeat (230) @(posedge clk);
  endtask
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // a hang counts as a mismatch
  initial begin
    #1000000 num_errors++;
    tally_and_finish;
  end
  // every applied step change takes the oldest note
  always @(posedge clk) begin
    if (!rst && step !== prev) chk(step, exp_q.pop_front(), "step");
    prev <= step;
  end
  initial begin
    {rst, uv, hl, ok, prev} = {4'h8, 4'h0};
    repeat (5) @(posedge clk);
    #1 rst = 0;
    host.pulse(2, 3);
    chk(en, 8'h01, "enable");
    chk(oe, 8'h3F, "sinks");
    for (int i = 1; i <= 16; i++) step_pulse(i[3:0], 4);
    step_pulse(4'h1, OFF - 12);
    chk(en, 8'h01, "enable");
    exp_q.push_back(4'h0);
    host.pulse(OFF + 4, 3);
    step_pulse(4'h1, 4);
    #1 hl = 1;
    repeat (13) @(posedge clk);
    chk(pr, 8'h01, "ratio");
    repeat (22) @(posedge clk);
    chk(pr, 8'h02, "ratio");
    repeat (12) @(posedge clk);
    chk(pr, 8'h03, "ratio");
    #1 {hl, ok} = 2'h1;
    repeat (2) @(posedge clk);
    chk(pr, 8'h00, "ratio");
    exp_q.push_back(4'h0);
    #1 uv = 1;
    repeat (2) @(posedge clk);
    chk(en, 8'h00, "uv");
    chk(oe, 8'h00, "sinks");
    chk(st, 8'h00, "settling");
    #1 uv = 0;
    repeat (5) @(posedge clk);
    tally_and_finish;
  end
endmodule // test_pulse_dimming_and_pump_mode_control
